// [logic/jlc_pkg.sv]
// Shared constants of the link configuration register bank
package jlc_pkg;
   // Register word indices on the bus (byte address is four times the index)
   localparam logic [2:0] JLC_IDX_DELAY  = 3'h0;
   localparam logic [2:0] JLC_IDX_CTRL1  = 3'h1;
   localparam logic [2:0] JLC_IDX_CTRL2  = 3'h2;
   localparam logic [2:0] JLC_IDX_STATUS = 3'h3;

   // Transceiver delay register fields
   localparam int JLC_B_XCVR_SEL = 7;     // Onboard transceiver select
   localparam int JLC_B_RX_POL   = 6;     // Receive pin polarity
   localparam int JLC_B_DLY_LO   = 0;     // Delay offset field, low bit
   localparam int JLC_B_DLY_HI   = 3;     // Delay offset field, high bit

   // Control one fields
   localparam int JLC_B_IGNORE_MESSAGE     = 7;     // Ignore message
   localparam int JLC_B_TBS      = 6;     // Time base select
   localparam int JLC_B_RATE_HI  = 5;     // Rate select, high
   localparam int JLC_B_RATE_LO  = 4;     // Rate select, low
   localparam int JLC_B_IE       = 1;     // Interrupt enable
   localparam int JLC_B_WCM      = 0;     // Wait clock stop

   // Control two fields
   localparam int JLC_B_ANALOG_LOOPBACK    = 7;     // Analog loopback
   localparam int JLC_B_DIGITAL_LOOPBACK    = 6;     // Digital loopback
   localparam int JLC_B_FAST     = 5;     // Fast receive enable

   // Status fields
   localparam int JLC_B_RX_RDY   = 0;
   localparam int JLC_B_TX_RDY   = 1;
   localparam int JLC_B_DLY_LCK  = 2;
   localparam int JLC_B_RATE_LCK = 3;

   // Reset values
   localparam logic [3:0] JLC_DELAY_RST  = 4'h7;   // 16 us expected delay
   localparam logic       JLC_RX_POL_RST = 1'b1;   // True polarity
   localparam logic [4:0] JLC_DELAY_BASE = 5'h09;  // Code zero means 9 us

   // Vectors
   localparam logic [7:0]  JLC_PASS_VECTOR  = 8'h20;    // Passes while ignoring
   localparam logic [15:0] JLC_BREAK_VECTOR = 16'h001C; // Loaded on break

   // Idle times in microseconds and bus time base ticks per microsecond
   localparam int JLC_EOF_IDLE_US = 280;
   localparam int JLC_IFS_IDLE_US = 300;
   localparam int JLC_TICKS_PER_US = 1;
   localparam int JLC_IDLE_W = 10;

   // Bus slave states, one-hot
   typedef enum logic [1:0] {
      JLC_BUS_IDLE = 2'b01,
      JLC_BUS_ANS  = 2'b10
   } jlc_bus_t;
endpackage

// [logic/jlc_rate_div.sv]
`timescale 1ns/1ps
// Divides the system clock into one-cycle bus time base ticks
module jlc_rate_div
   import jlc_pkg::*;
#(
   parameter int CNT_W = 3
) (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic [1:0] rate,
   output logic            tick
);
   initial begin
      if (CNT_W < 3) $error("jlc_rate_div: counter too narrow for divide by 8");
   end

   typedef struct packed {
      logic [CNT_W-1:0] cnt;   // Cycles since the last tick
      logic             tick;  // Registered tick
   } jlc_div_st_t;

   jlc_div_st_t st;
   jlc_div_st_t next_st;
   logic [CNT_W-1:0] last;   // Terminal count for the selected divide

   // Divide by 1, 2, 4 or 8 from the two rate bits
   always_comb begin
      last    = CNT_W'((1 << rate) - 1); // RULE9
      next_st = st;
      if (st.cnt >= last) begin
         next_st.cnt  = '0;
         next_st.tick = 1'b1;
      end else begin
         next_st.cnt  = st.cnt + 1'b1;
         next_st.tick = 1'b0;
      end
   end

   // State register
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tick = st.tick;

   // Above divide by one, ticks never follow back to back
   property p_div_gap;
      @(posedge mclk) disable iff (rst) (tick && rate != 2'b00 && $stable(rate)) |=> !tick;
   endproperty
   a_div_gap: assert property (p_div_gap) else $error("tick repeated too soon"); // RULE9
endmodule

// [logic/jlc_link_cfg.sv]
// Contract
// (RULE1) Delay register accepts one write per reset
// (RULE2) Delay starts at sixteen microseconds
// (RULE3) Delay is nine plus offset microseconds
// (RULE4) Software keeps transceiver select at zero
// (RULE5) Polarity one passes, zero inverts receive
// (RULE6) Ignore disables receiver, holds status, masks interrupts
// (RULE7) Start or break symbol clears ignore
// (RULE8) Time base select picks binary or integer
// (RULE9) Rate field divides clock by 1,2,4,8
// (RULE10) Rate field accepts one write per reset
// (RULE11) Software avoids divide by four or eight
// (RULE12) Enable gates run requests, not wake requests
// (RULE13) Request held while its sources stay pending
// (RULE14) Wait clock bit stops clocks during wait
// (RULE15) Analog loopback loops drive, bus undriven
// (RULE16) After analog loopback, wait idle before use
// (RULE17) Digital loopback feeds transmit into receive
// (RULE18) After digital loopback, wait idle before use
// (RULE19) Fast receive is receive only
// (RULE20) Break clears fast receive, loads vector
// (RULE21) Software changes control two bitwise only
// (RULE22) Loopback selector picks transmit or receive pin
// (RULE23) Registers eight bits, unnamed bits read zero
`timescale 1ns/1ps
module jlc_link_cfg
   import jlc_pkg::*;
#(
   parameter int EOF_IDLE_US = JLC_EOF_IDLE_US,  // Idle before reception
   parameter int IFS_IDLE_US = JLC_IFS_IDLE_US   // Idle before transmission
) (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic [2:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        rx_pin,
   input  wire logic        tx_from_engine,
   input  wire logic        sof_seen,
   input  wire logic        break_seen,
   input  wire logic        engine_irq,
   input  wire logic [7:0]  engine_vector,
   input  wire logic        wake_irq,
   input  wire logic        cpu_wait,
   output logic             tx_pin_out,
   output logic             rx_to_engine,
   output logic             rx_enable,
   output logic             tx_enable,
   output logic             status_hold,
   output logic             cpu_irq,
   output logic             svr_load,
   output logic [15:0]      svr_load_value,
   output logic             bus_tick,
   output logic             fast_mode,
   output logic             time_base_binary,
   output logic             onboard_xcvr_select,
   output logic [4:0]       xcvr_delay_us,
   output logic             internal_clk_run
);
   localparam int EOF_TICKS = EOF_IDLE_US * JLC_TICKS_PER_US;
   localparam int IFS_TICKS = IFS_IDLE_US * JLC_TICKS_PER_US;

   initial begin
      if (EOF_TICKS < 1 || IFS_TICKS < 1 || EOF_TICKS >= (1 << JLC_IDLE_W) || IFS_TICKS >= (1 << JLC_IDLE_W))
         $error("jlc_link_cfg: idle times out of counter range");
   end

   // All state of the block
   typedef struct packed {
      jlc_bus_t              bus_st;      // Bus slave phase
      logic                  waitreq;     // Registered waitrequest
      logic [7:0]            rdata;       // Registered read data
      logic                  rx_s1;       // Pin synchroniser, first stage
      logic                  rx_s2;       // Pin synchroniser, second stage
      logic                  xcvr_sel;    // Onboard transceiver select
      logic                  rx_pol;      // Receive pin polarity
      logic [3:0]            delay;       // Delay offset field
      logic                  delay_lock;  // Delay register written once
      logic                  ignore_message;        // Ignore message
      logic                  tbs;         // Time base select
      logic [1:0]            rate;        // Rate select
      logic                  rate_lock;   // Rate field written once
      logic                  ie;          // Interrupt enable
      logic                  wait_clock_stop;         // Wait clock stop
      logic                  analog_loopback;       // Analog loopback
      logic                  digital_loopback;       // Digital loopback
      logic                  fast;        // Fast receive enable
      logic [JLC_IDLE_W-1:0] idle_cnt;    // Idle ticks seen on the bus
      logic                  rx_gate;     // Reception allowed
      logic                  tx_gate;     // Transmission allowed
      logic                  tx_out;      // Pin drive
      logic                  rx_out;      // Receive path to the engine
      logic                  irq;         // Interrupt request to the CPU
      logic                  svr_load;    // Vector load strobe
      logic                  clk_run;     // Internal clocks running
      logic [4:0]            delay_us;    // Expected delay in microseconds
      logic                  rx_en;       // Reception allowed and not ignoring
      logic                  tx_en;       // Transmission allowed and not fast
   } jlc_st_t;

   jlc_st_t    st;
   jlc_st_t    next_st;
   logic       tick;      // Bus time base tick
   logic       rx_true;   // Pin level corrected for polarity
   logic       wr_take;   // Write commits this edge
   logic [7:0] wbyte;     // Low byte of write data

   // Bus time base divider
   jlc_rate_div #(
      .CNT_W (3)
   ) u_div (
      .mclk (mclk),
      .rst  (rst),
      .rate (st.rate),
      .tick (tick)
   );

   // Next state of everything
   always_comb begin
      next_st = st;
      wbyte   = avs_writedata[7:0];
      wr_take = (st.bus_st == JLC_BUS_ANS) && avs_write && avs_byteenable[0];

      // Two flip-flops before the pin is looked at
      next_st.rx_s1 = rx_pin;
      next_st.rx_s2 = st.rx_s1;

      // Bus slave: request taken in idle, answered one cycle later
      case (st.bus_st)
         JLC_BUS_IDLE: begin
            if (avs_read || avs_write) begin
               next_st.bus_st  = JLC_BUS_ANS;
               next_st.waitreq = 1'b0;
               // Read decode; unnamed bits and unmapped words read zero
               if (avs_address == JLC_IDX_DELAY) begin
                  next_st.rdata = 8'h00; // RULE23
                  next_st.rdata[JLC_B_XCVR_SEL] = st.xcvr_sel;
                  next_st.rdata[JLC_B_RX_POL] = st.rx_pol;
                  next_st.rdata[JLC_B_DLY_HI:JLC_B_DLY_LO] = st.delay;
               end else if (avs_address == JLC_IDX_CTRL1) begin
                  next_st.rdata = 8'h00;
                  next_st.rdata[JLC_B_IGNORE_MESSAGE] = st.ignore_message;
                  next_st.rdata[JLC_B_TBS] = st.tbs;
                  next_st.rdata[JLC_B_RATE_HI] = st.rate[1];
                  next_st.rdata[JLC_B_RATE_LO] = st.rate[0];
                  next_st.rdata[JLC_B_IE] = st.ie;
                  next_st.rdata[JLC_B_WCM] = st.wait_clock_stop;
               end else if (avs_address == JLC_IDX_CTRL2) begin
                  next_st.rdata = 8'h00;
                  next_st.rdata[JLC_B_ANALOG_LOOPBACK] = st.analog_loopback;
                  next_st.rdata[JLC_B_DIGITAL_LOOPBACK] = st.digital_loopback;
                  next_st.rdata[JLC_B_FAST] = st.fast;
               end else if (avs_address == JLC_IDX_STATUS) begin
                  next_st.rdata = 8'h00;
                  next_st.rdata[JLC_B_RX_RDY] = st.rx_gate;
                  next_st.rdata[JLC_B_TX_RDY] = st.tx_gate;
                  next_st.rdata[JLC_B_DLY_LCK] = st.delay_lock;
                  next_st.rdata[JLC_B_RATE_LCK] = st.rate_lock;
               end else begin
                  next_st.rdata = 8'h00;
               end
            end
         end
         JLC_BUS_ANS: begin
            // Master samples waitrequest low at this edge
            next_st.bus_st  = JLC_BUS_IDLE;
            next_st.waitreq = 1'b1;
         end
         default: begin
            next_st.bus_st  = JLC_BUS_IDLE;
            next_st.waitreq = 1'b1;
         end
      endcase

      // Register writes
      if (wr_take) begin
         if (avs_address == JLC_IDX_DELAY) begin
            // Later writes are dropped silently
            if (!st.delay_lock) begin // RULE1
               next_st.xcvr_sel   = wbyte[JLC_B_XCVR_SEL];
               next_st.rx_pol     = wbyte[JLC_B_RX_POL];
               next_st.delay      = wbyte[JLC_B_DLY_HI:JLC_B_DLY_LO];
               next_st.delay_lock = 1'b1;
            end
         end else if (avs_address == JLC_IDX_CTRL1) begin
            next_st.ignore_message = wbyte[JLC_B_IGNORE_MESSAGE];
            next_st.tbs  = wbyte[JLC_B_TBS];
            next_st.ie   = wbyte[JLC_B_IE];
            next_st.wait_clock_stop  = wbyte[JLC_B_WCM];
            // Changing the divider mid-frame would break symbol timing
            if (!st.rate_lock) begin // RULE10
               next_st.rate      = {wbyte[JLC_B_RATE_HI], wbyte[JLC_B_RATE_LO]};
               next_st.rate_lock = 1'b1;
            end
         end else if (avs_address == JLC_IDX_CTRL2) begin
            next_st.analog_loopback = wbyte[JLC_B_ANALOG_LOOPBACK];
            next_st.digital_loopback = wbyte[JLC_B_DIGITAL_LOOPBACK];
            next_st.fast  = wbyte[JLC_B_FAST];
         end
      end

      // Frame start or break ends ignoring; beats a software write the same cycle
      if (sof_seen || break_seen) begin
         next_st.ignore_message = 1'b0; // RULE7
      end

      // Break drops back to normal speed
      if (break_seen) begin
         next_st.fast = 1'b0; // RULE20
      end
      next_st.svr_load = break_seen; // RULE20

      // Receive path: polarity, then loopback selection
      if (st.digital_loopback) begin
         next_st.rx_out = tx_from_engine; // RULE17 RULE22
      end else if (st.analog_loopback) begin
         next_st.rx_out = tx_from_engine; // RULE15
      end else begin
         next_st.rx_out = rx_true; // RULE5 RULE22
      end

      // Pin stays passive in either loopback
      next_st.tx_out = tx_from_engine && !st.analog_loopback && !st.digital_loopback; // RULE15

      // Idle timing on the true bus after loopback ends
      if (st.analog_loopback || st.digital_loopback || rx_true) begin
         next_st.idle_cnt = '0;
         next_st.rx_gate  = 1'b0; // RULE16 RULE18
         next_st.tx_gate  = 1'b0; // RULE16 RULE18
      end else if (tick) begin
         if (st.idle_cnt != '1) begin
            next_st.idle_cnt = st.idle_cnt + 1'b1;
         end
         if (st.idle_cnt >= JLC_IDLE_W'(EOF_TICKS - 1)) begin
            next_st.rx_gate = 1'b1; // RULE16 RULE18
         end
         if (st.idle_cnt >= JLC_IDLE_W'(IFS_TICKS - 1)) begin
            next_st.tx_gate = 1'b1; // RULE16 RULE18
         end
      end

      // Interrupt: wake requests ungated, run requests gated by enable and ignore
      next_st.irq = wake_irq || // RULE12
                    (st.ie && engine_irq && (!st.ignore_message || engine_vector == JLC_PASS_VECTOR)); // RULE6 RULE13

      // Clocks stop in CPU wait only when asked
      next_st.clk_run  = !(st.wait_clock_stop && cpu_wait); // RULE14
      next_st.delay_us = JLC_DELAY_BASE + {1'b0, st.delay}; // RULE3

      // Gates taken from the next state so the flops agree with the bits they follow
      next_st.rx_en = next_st.rx_gate && !next_st.ignore_message; // RULE6
      next_st.tx_en = next_st.tx_gate && !next_st.fast; // RULE19
   end

   // Polarity correction of the synchronised pin
   assign rx_true = st.rx_pol ? st.rx_s2 : !st.rx_s2; // RULE5

   // State register
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st          <= '0;
         st.bus_st   <= JLC_BUS_IDLE;
         st.waitreq  <= 1'b1;
         st.rx_pol   <= JLC_RX_POL_RST;
         st.delay    <= JLC_DELAY_RST; // RULE2
         st.delay_us <= JLC_DELAY_BASE + {1'b0, JLC_DELAY_RST};
         st.clk_run  <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // Outputs from flip-flops, except the constant break vector on svr_load_value
   assign avs_readdata        = {24'h0000_00, st.rdata};
   assign avs_waitrequest     = st.waitreq;
   assign tx_pin_out          = st.tx_out;
   assign rx_to_engine        = st.rx_out;
   assign rx_enable           = st.rx_en; // RULE6
   assign tx_enable           = st.tx_en; // RULE19
   assign status_hold         = st.ignore_message; // RULE6
   assign cpu_irq             = st.irq;
   assign svr_load            = st.svr_load;
   assign svr_load_value      = JLC_BREAK_VECTOR;
   assign bus_tick            = tick; // RULE9
   assign fast_mode           = st.fast; // RULE19
   assign time_base_binary    = st.tbs; // RULE8
   assign onboard_xcvr_select = st.xcvr_sel;
   assign xcvr_delay_us       = st.delay_us;
   assign internal_clk_run    = st.clk_run;

   // Checks
   sequence s_loop_off;
      $fell(st.analog_loopback || st.digital_loopback);
   endsequence
   sequence s_break_answer;
      svr_load && !fast_mode;
   endsequence

   property p_delay_once;
      @(posedge mclk) disable iff (rst) st.delay_lock |=> $stable(st.delay);
   endproperty
   a_delay_once: assert property (p_delay_once) else $error("delay changed after lock"); // RULE1

   property p_delay_rst;
      @(posedge mclk) disable iff (rst) !st.delay_lock |-> xcvr_delay_us == 5'h10;
   endproperty
   a_delay_rst: assert property (p_delay_rst) else $error("default delay not 16 us"); // RULE2

   property p_delay_us;
      @(posedge mclk) disable iff (rst) ##1 1'b1 |-> xcvr_delay_us == JLC_DELAY_BASE + {1'b0, $past(st.delay)};
   endproperty
   a_delay_us: assert property (p_delay_us) else $error("delay microseconds wrong"); // RULE3

   property p_pol;
      @(posedge mclk) disable iff (rst) (!st.digital_loopback && !st.analog_loopback) |=> rx_to_engine == $past(rx_true);
   endproperty
   a_pol: assert property (p_pol) else $error("receive polarity wrong"); // RULE5

   property p_ignore;
      @(posedge mclk) disable iff (rst) st.ignore_message |-> !rx_enable && status_hold;
   endproperty
   a_ignore: assert property (p_ignore) else $error("receiver active while ignoring"); // RULE6

   property p_sof_clear;
      @(posedge mclk) disable iff (rst) (sof_seen || break_seen) |=> !status_hold;
   endproperty
   a_sof_clear: assert property (p_sof_clear) else $error("ignore not cleared by frame start"); // RULE7

   property p_rate_once;
      @(posedge mclk) disable iff (rst) st.rate_lock |=> $stable(st.rate);
   endproperty
   a_rate_once: assert property (p_rate_once) else $error("rate changed after lock"); // RULE10

   property p_wake;
      @(posedge mclk) disable iff (rst) wake_irq |=> cpu_irq;
   endproperty
   a_wake: assert property (p_wake) else $error("wake request lost"); // RULE12

   property p_wait_clk;
      @(posedge mclk) disable iff (rst) (st.wait_clock_stop && cpu_wait) |=> !internal_clk_run;
   endproperty
   a_wait_clk: assert property (p_wait_clk) else $error("clocks not stopped in wait"); // RULE14

   property p_analog_loopback;
      @(posedge mclk) disable iff (rst) st.analog_loopback |=> !tx_pin_out;
   endproperty
   a_analog_loopback: assert property (p_analog_loopback) else $error("bus driven in analog loopback"); // RULE15

   property p_loop_exit;
      @(posedge mclk) disable iff (rst) s_loop_off |-> (!tx_enable && !rx_enable) [*2];
   endproperty
   a_loop_exit: assert property (p_loop_exit) else $error("link usable right after loopback"); // RULE16

   property p_digital_loopback;
      @(posedge mclk) disable iff (rst) st.digital_loopback |=> rx_to_engine == $past(tx_from_engine);
   endproperty
   a_digital_loopback: assert property (p_digital_loopback) else $error("digital loopback path wrong"); // RULE17

   property p_fast;
      @(posedge mclk) disable iff (rst) fast_mode |-> !tx_enable;
   endproperty
   a_fast: assert property (p_fast) else $error("transmit allowed in fast receive"); // RULE19

   property p_break;
      @(posedge mclk) disable iff (rst) break_seen |=> s_break_answer;
   endproperty
   a_break: assert property (p_break) else $error("break not handled"); // RULE20
endmodule

// [bench/jlc_xcvr_model.sv]
`timescale 1ns/1ps
// Off-chip transceiver: our drive and other nodes share a passive-low bus,
// and the receive line may come back inverted, as some parts do
module jlc_xcvr_model (
   input  wire logic drive,   // Transmit line from the link
   input  wire logic others,  // Activity of other nodes
   input  wire logic invert,  // Transceiver inverts its receive output
   output logic      rx_pin   // Receive line to the link
);
   logic bus_level;  // Wired-or of every driver
   assign bus_level = drive | others;
   assign rx_pin    = bus_level ^ invert;
endmodule

// [bench/tb_jlc_link_cfg.sv]
`timescale 1ns/1ps
module tb_jlc_link_cfg;
   import jlc_pkg::*;
   logic mclk = 0, rst = 1, avs_read = 0, avs_write = 0, tx_from_engine = 0, sof_seen = 0, break_seen = 0;
   logic engine_irq = 0, wake_irq = 0, cpu_wait = 0, others = 0, invert = 1, rx_pin;
   logic [2:0] avs_address = 3'h0;
   logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata;
   logic [3:0] avs_byteenable = 4'h1;
   logic [7:0] engine_vector = 8'h00, rd;
   logic avs_waitrequest, tx_pin_out, rx_to_engine, rx_enable, tx_enable, status_hold, cpu_irq, svr_load;
   logic bus_tick, fast_mode, time_base_binary, onboard_xcvr_select, internal_clk_run;
   logic [15:0] svr_load_value;
   logic [4:0] xcvr_delay_us;
   int n_mismatch = 0, num_checks = 0;
   jlc_link_cfg #(.EOF_IDLE_US(4), .IFS_IDLE_US(6)) dut (.mclk(mclk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_pin(rx_pin),
      .tx_from_engine(tx_from_engine), .sof_seen(sof_seen), .break_seen(break_seen), .engine_irq(engine_irq),
      .engine_vector(engine_vector), .wake_irq(wake_irq), .cpu_wait(cpu_wait), .tx_pin_out(tx_pin_out),
      .rx_to_engine(rx_to_engine), .rx_enable(rx_enable), .tx_enable(tx_enable), .status_hold(status_hold),
      .cpu_irq(cpu_irq), .svr_load(svr_load), .svr_load_value(svr_load_value), .bus_tick(bus_tick),
      .fast_mode(fast_mode), .time_base_binary(time_base_binary), .onboard_xcvr_select(onboard_xcvr_select),
      .xcvr_delay_us(xcvr_delay_us), .internal_clk_run(internal_clk_run));
   jlc_xcvr_model xcvr (.drive(tx_pin_out), .others(others), .invert(invert), .rx_pin(rx_pin));
   // Clock at 20 MHz
   initial begin
      forever #25 mclk = ~mclk;
   end
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // Bus write; waits for the slave however long it takes
   task automatic bus_wr(input logic [2:0] a, input logic [7:0] d, input logic [3:0] be);
      avs_address <= a;
      avs_writedata <= {24'h00_0000, d};
      avs_byteenable <= be;
      avs_write <= 1'b1;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      d = avs_readdata[7:0];
      avs_read <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic do_reset;
      rst <= 1'b1;
      cyc(5);
      rst <= 1'b0;
      @(posedge mclk);
   endtask
   // Reset values, write-once delay with one offset code, unmapped place
   task automatic t_delay(input logic [3:0] code);
      do_reset();
      bus_rd(JLC_IDX_DELAY, rd); chk(rd, 8'h47);
      chk(xcvr_delay_us, 5'd16);
      bus_rd(JLC_IDX_CTRL2, rd); chk(rd, 8'h00);
      chk(rx_to_engine, 1'b1);
      bus_wr(3'h5, 8'hFF, 4'h1); bus_rd(3'h5, rd); chk(rd, 8'h00);
      bus_wr(JLC_IDX_DELAY, {4'h0, code}, 4'h1);
      bus_wr(JLC_IDX_DELAY, 8'h4A, 4'h1);
      cyc(2);
      bus_rd(JLC_IDX_DELAY, rd); chk(rd, {4'h0, code});
      chk(xcvr_delay_us, 5'd9 + code);
      chk(onboard_xcvr_select, 1'b0);
   endtask
   // Inverting transceiver with polarity zero gives the true bus level
   task automatic t_polarity;
      others <= 1'b1; cyc(6); chk(rx_to_engine, 1'b1);
      others <= 1'b0; cyc(6); chk(rx_to_engine, 1'b0);
   endtask
   // Time base, divide by two, rate locked after one write
   task automatic t_rate;
      int n;
      bus_wr(JLC_IDX_CTRL1, 8'h50, 4'h1);
      cyc(2); chk(time_base_binary, 1'b1);
      n = 0;
      repeat (16) begin
         @(posedge mclk);
         if (bus_tick === 1'b1) n++;
      end
      chk(n, 8);
      bus_wr(JLC_IDX_CTRL1, 8'h30, 4'h1);
      bus_rd(JLC_IDX_CTRL1, rd); chk(rd, 8'h10);
      cyc(2); chk(time_base_binary, 1'b0);
   endtask
   // Ignore, enable, wake requests and wait clock stop
   task automatic t_irq;
      engine_irq <= 1'b1; engine_vector <= 8'h33;
      bus_wr(JLC_IDX_CTRL1, 8'h82, 4'h1);
      cyc(2); chk(status_hold, 1'b1); chk(cpu_irq, 1'b0);
      engine_vector <= JLC_PASS_VECTOR; cyc(2); chk(cpu_irq, 1'b1);
      engine_vector <= 8'h33; sof_seen <= 1'b1; @(posedge mclk); sof_seen <= 1'b0;
      cyc(3); chk(status_hold, 1'b0); chk(cpu_irq, 1'b1);
      cyc(5); chk(cpu_irq, 1'b1);
      bus_wr(JLC_IDX_CTRL1, 8'h10, 4'h1); cyc(2); chk(cpu_irq, 1'b0);
      wake_irq <= 1'b1; cyc(2); chk(cpu_irq, 1'b1);
      wake_irq <= 1'b0; engine_irq <= 1'b0;
      cpu_wait <= 1'b1; cyc(2); chk(internal_clk_run, 1'b1);
      bus_wr(JLC_IDX_CTRL1, 8'h11, 4'h1); cyc(2); chk(internal_clk_run, 1'b0);
      cpu_wait <= 1'b0; cyc(2); chk(internal_clk_run, 1'b1);
   endtask
   // Fast receive, break, both loopbacks and the idle wait after them
   task automatic t_ctrl2;
      int n;
      bus_wr(JLC_IDX_CTRL2, 8'hFF, 4'h0); bus_rd(JLC_IDX_CTRL2, rd); chk(rd, 8'h00);
      bus_wr(JLC_IDX_CTRL2, 8'h20, 4'h1);
      cyc(2); chk(fast_mode, 1'b1); chk(tx_enable, 1'b0);
      break_seen <= 1'b1; @(posedge mclk); break_seen <= 1'b0;
      @(posedge mclk); chk(svr_load, 1'b1); chk(svr_load_value, JLC_BREAK_VECTOR);
      @(posedge mclk); chk(svr_load, 1'b0); chk(fast_mode, 1'b0);
      bus_wr(JLC_IDX_CTRL2, 8'h40, 4'h1); tx_from_engine <= 1'b1;
      cyc(4); chk(rx_to_engine, 1'b1); chk(tx_pin_out, 1'b0);
      bus_wr(JLC_IDX_CTRL2, 8'hC0, 4'h1); bus_wr(JLC_IDX_CTRL2, 8'h80, 4'h1);
      cyc(2); chk(tx_pin_out, 1'b0); chk(rx_enable, 1'b0);
      chk(rx_to_engine, 1'b1);
      tx_from_engine <= 1'b0;
      bus_wr(JLC_IDX_CTRL2, 8'h00, 4'h1); cyc(2); chk(rx_enable, 1'b0);
      n = 0;
      while (tx_enable !== 1'b1 && n < 200) begin
         @(posedge mclk);
         n++;
      end
      chk(rx_enable, 1'b1); chk(tx_enable, 1'b1);
      bus_rd(JLC_IDX_STATUS, rd); chk(rd, 8'h0F);
      tx_from_engine <= 1'b1; cyc(2); chk(tx_pin_out, 1'b1);
   endtask
   task automatic report_and_stop;
      $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Watchdog: the whole sequence needs well under a millisecond
   initial begin
      #2ms;
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      @(posedge mclk);
      t_delay(4'h0);
      t_delay(4'hF);
      t_delay(4'h7);
      t_polarity();
      t_rate();
      t_irq();
      t_ctrl2();
      report_and_stop();
   end
endmodule
